/* logic/pc_compat_peripheral_glue.sv */
// PC compatibility glue: interrupt routing, timebase, DMA trap and remap, wait states.
`timescale 1ns/1ps
`include "glue_defs.svh"

module pc_compat_peripheral_glue #(
  parameter int TB_DIV = `TB_DIV_DEF
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Wishbone register slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Processor bus cycles.
  input wire glue_pkg::cpu_cyc_t cpu_cyc_i,
  output logic cpu_ready_o,
  output logic nmi_o,
  // Counter timer unit.
  output logic timer_tick_o,
  input wire logic timer_ch0_out_i,
  input wire logic timer_ch1_out_i,
  input wire logic timer_ch2_out_i,
  output logic serial_baud_o,
  output logic speaker_tone_o,
  // Interrupt requests.
  input wire logic [7:2] bus_irq_i,
  input wire logic kbd_irq_i,
  output logic [7:0] irq_o,
  // DMA and refresh.
  input wire logic [3:1] bus_drq_i,
  output logic [3:0] bus_dack_o,
  output logic [3:0] dma_req_o,
  input wire logic [2:0] dma_ack_i,
  input wire logic refresh_req_i,
  input wire logic dma_wait_jumper_i
);
  import glue_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [10:0] pin_meta_r;
  logic [10:0] pin_sync_r;
  logic [7:2] irq_s;
  logic kbd_s;
  logic [2:0] drq_s;
  logic jumper_s;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {dma_wait_jumper_i, bus_drq_i, kbd_irq_i, bus_irq_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign {jumper_s, drq_s, kbd_s, irq_s} = pin_sync_r;

  // ----------------------------------------
  // Timebase and signal routing
  // ----------------------------------------
  logic [2:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  logic [7:0] irq_r, irq_nxt;
  logic baud_r, baud_nxt;
  logic tone_r, tone_nxt;
  logic [3:0] dack_r, dack_nxt;

  always_comb begin
    tick_nxt = (div_r == 3'(TB_DIV - 1));
    div_nxt = tick_nxt ? 3'h0 : div_r + 3'h1;
    irq_nxt = {irq_s, kbd_s, timer_ch0_out_i};
    baud_nxt = timer_ch1_out_i;
    tone_nxt = timer_ch2_out_i;
    // Legacy acknowledge n is native acknowledge n-1; legacy 0 flags refresh.
    dack_nxt = {dma_ack_i, refresh_req_i};
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r <= 3'h0;
      tick_r <= 1'b0;
      irq_r <= 8'h00;
      baud_r <= 1'b0;
      tone_r <= 1'b0;
      dack_r <= 4'h0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      irq_r <= irq_nxt;
      baud_r <= baud_nxt;
      tone_r <= tone_nxt;
      dack_r <= dack_nxt;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [11:0] wcfg_r, wcfg_nxt;
  logic [7:0] region_r, region_nxt;
  logic rot_r, rot_nxt;
  logic wb_wr;
  logic trap_clr;
  logic nmi_r;
  logic tdir_r;
  logic [9:0] taddr_r;
  logic [2:0] grant_r;

  // Writes land on the edge at which the master sees ack.
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign trap_clr = wb_wr & (wb_adr_i == `TRAP_OFS) & wb_sel_i[0] & wb_dat_i[`TR_FLAG_BIT];

  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    wcfg_nxt = wcfg_r;
    region_nxt = region_r;
    rot_nxt = rot_r;
    if (wb_wr) begin
      case (wb_adr_i)
        `WAIT_CFG_OFS: begin
          if (wb_sel_i[0]) wcfg_nxt[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) wcfg_nxt[11:8] = wb_dat_i[11:8];
        end
        `REGION_OFS: begin
          if (wb_sel_i[0]) region_nxt = wb_dat_i[7:0];
        end
        `DMA_CTRL_OFS: begin
          if (wb_sel_i[0]) rot_nxt = wb_dat_i[`DC_ROT_BIT];
        end
        default: begin
        end
      endcase
    end
    dat_nxt = 32'h0;
    case (wb_adr_i)
      `WAIT_CFG_OFS: dat_nxt[11:0] = wcfg_r;
      `REGION_OFS: dat_nxt[7:0] = region_r;
      `TRAP_OFS: begin
        dat_nxt[`TR_FLAG_BIT] = nmi_r;
        dat_nxt[`TR_DIR_BIT] = tdir_r;
        dat_nxt[`TR_ADDR_LSB +: 10] = taddr_r;
      end
      `STATUS_OFS: begin
        dat_nxt[`ST_IRQ_LSB +: 8] = irq_r;
        dat_nxt[`ST_REF_BIT] = dack_r[0];
        dat_nxt[`ST_JMP_BIT] = jumper_s;
        dat_nxt[`ST_GNT_LSB +: 3] = grant_r;
      end
      `DMA_CTRL_OFS: dat_nxt[`DC_ROT_BIT] = rot_r;
      default: dat_nxt = 32'h0;
    endcase
    if (!ack_nxt) dat_nxt = dat_r;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      wcfg_r <= `WC_RESET;
      region_r <= `RG_RESET;
      rot_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      wcfg_r <= wcfg_nxt;
      region_r <= region_nxt;
      rot_r <= rot_nxt;
    end
  end

  // ----------------------------------------
  // Wait states and legacy DMA trap
  // ----------------------------------------
  ws_state_t ws_r, ws_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [1:0] mem_ws;
  logic [2:0] load;
  logic legacy;
  logic nmi_nxt;
  logic tdir_nxt;
  logic [9:0] taddr_nxt;

  always_comb begin
    if (cpu_cyc_i.addr[19:16] >= region_r[`RG_R2_LSB +: 4]) begin
      mem_ws = wcfg_r[`WC_MEM2_LSB +: 2];
    end else if (cpu_cyc_i.addr[19:16] >= region_r[`RG_R1_LSB +: 4]) begin
      mem_ws = wcfg_r[`WC_MEM1_LSB +: 2];
    end else begin
      mem_ws = wcfg_r[`WC_MEM0_LSB +: 2];
    end
    unique case (cpu_cyc_i.kind)
      CYC_MEM: load = {1'b0, mem_ws};
      CYC_IO: load = {1'b0, wcfg_r[`WC_IO_LSB +: 2]};
      CYC_REF: load = {1'b0, wcfg_r[`WC_REF_LSB +: 2]};
      CYC_DMA: begin
        if (jumper_s == `JMP_FIXED) begin
          load = `DMA_FIXED_WAIT;
        end else if (wcfg_r[`WC_DMA_LSB +: 2] == 2'h0) begin
          load = 3'h1;
        end else begin
          load = {1'b0, wcfg_r[`WC_DMA_LSB +: 2]};
        end
      end
    endcase
    ws_nxt = ws_r;
    cnt_nxt = cnt_r;
    unique case (ws_r)
      WS_IDLE: begin
        if (cpu_cyc_i.start && load != 3'h0) begin
          ws_nxt = WS_BUSY;
          cnt_nxt = load;
        end
      end
      WS_BUSY: begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h1) ws_nxt = WS_IDLE;
      end
      default: ws_nxt = WS_IDLE;
    endcase
    // Only the legacy ranges trap; the native block is reached untouched.
    legacy = (cpu_cyc_i.addr[9:0] <= `LEG_DMA_HI) ||
             (cpu_cyc_i.addr[9:0] >= `LEG_PAGE_LO && cpu_cyc_i.addr[9:0] <= `LEG_PAGE_HI);
    nmi_nxt = nmi_r & ~trap_clr;
    tdir_nxt = tdir_r;
    taddr_nxt = taddr_r;
    if (cpu_cyc_i.start && cpu_cyc_i.kind == CYC_IO && legacy) begin
      nmi_nxt = 1'b1;
      tdir_nxt = cpu_cyc_i.wr;
      taddr_nxt = cpu_cyc_i.addr[9:0];
    end
  end

  assign cpu_ready_o = (ws_r == WS_IDLE) ? (!cpu_cyc_i.start || load == 3'h0) : (cnt_r == 3'h1);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ws_r <= WS_IDLE;
      cnt_r <= 3'h0;
      nmi_r <= 1'b0;
      tdir_r <= 1'b0;
      taddr_r <= 10'h000;
    end else begin
      ws_r <= ws_nxt;
      cnt_r <= cnt_nxt;
      nmi_r <= nmi_nxt;
      tdir_r <= tdir_nxt;
      taddr_r <= taddr_nxt;
    end
  end

  // ----------------------------------------
  // DMA channel arbitration
  // ----------------------------------------
  logic [2:0] grant_nxt;
  logic [1:0] last_r, last_nxt;

  // Legacy request n enters native channel n-1: floppy on one, disk on two.
  always_comb begin
    int idx;
    idx = 0;
    grant_nxt = grant_r & drq_s;
    last_nxt = last_r;
    if (grant_nxt == 3'h0) begin
      for (int k = 2; k >= 0; k--) begin
        idx = (rot_r ? int'(last_r) + 1 + k : k) % 3;
        if (drq_s[idx]) begin
          grant_nxt = 3'(3'h1 << idx);
          last_nxt = 2'(idx);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      grant_r <= 3'h0;
      last_r <= 2'h2;
    end else begin
      grant_r <= grant_nxt;
      last_r <= last_nxt;
    end
  end

  assign dma_req_o = {1'b0, grant_r};
  assign bus_dack_o = dack_r;
  assign irq_o = irq_r;
  assign serial_baud_o = baud_r;
  assign speaker_tone_o = tone_r;
  assign timer_tick_o = tick_r;
  assign nmi_o = nmi_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking dflt_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_three_waits;
    !cpu_ready_o [*3] ##1 cpu_ready_o;
  endsequence
  sequence s_five_waits;
    !cpu_ready_o [*5] ##1 cpu_ready_o;
  endsequence

  property p_tick_period;
    timer_tick_o |=> !timer_tick_o [*5] ##1 timer_tick_o;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("timebase tick not every sixth clock");
  property p_irq_pins;
    $past(arst_n_i, 3) |-> irq_o[7:2] == $past(bus_irq_i, 3);
  endproperty
  a_irq_pins: assert property (p_irq_pins) else $error("bus interrupt lines misrouted");
  property p_irq_timer;
    $past(arst_n_i) |-> irq_o[0] == $past(timer_ch0_out_i);
  endproperty
  a_irq_timer: assert property (p_irq_timer) else $error("line 0 not from timer zero");
  property p_trap;
    cpu_cyc_i.start && cpu_cyc_i.kind == CYC_IO && cpu_cyc_i.addr[9:0] <= `LEG_DMA_HI
      |=> nmi_o && taddr_r == $past(cpu_cyc_i.addr[9:0]) && tdir_r == $past(cpu_cyc_i.wr);
  endproperty
  a_trap: assert property (p_trap) else $error("legacy DMA access not trapped");
  property p_no_trap;
    cpu_cyc_i.start && cpu_cyc_i.kind == CYC_IO && cpu_cyc_i.addr[9:0] > `LEG_PAGE_HI && !nmi_o |=> !nmi_o;
  endproperty
  a_no_trap: assert property (p_no_trap) else $error("native access trapped");
  property p_dack0;
    $past(arst_n_i) |-> bus_dack_o[0] == $past(refresh_req_i);
  endproperty
  a_dack0: assert property (p_dack0) else $error("DACK0 does not follow refresh");
  property p_io_wait;
    ws_r == WS_IDLE && cpu_cyc_i.start && cpu_cyc_i.kind == CYC_IO && wcfg_r[`WC_IO_LSB +: 2] == 2'h3
      |-> s_three_waits;
  endproperty
  a_io_wait: assert property (p_io_wait) else $error("I/O wait count wrong");
  property p_dma_fixed;
    ws_r == WS_IDLE && cpu_cyc_i.start && cpu_cyc_i.kind == CYC_DMA && jumper_s == `JMP_FIXED |-> s_five_waits;
  endproperty
  a_dma_fixed: assert property (p_dma_fixed) else $error("fixed DMA waits not five");
  property p_grant;
    $onehot0(dma_req_o) && !dma_req_o[3];
  endproperty
  a_grant: assert property (p_grant) else $error("DMA grant not one-hot on three channels");
  property p_wb_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack held two cycles");
endmodule : pc_compat_peripheral_glue

/* shared/glue_defs.svh */
// Register offsets, field positions, reset values and counts for the PC compatibility glue.
`ifndef GLUE_DEFS_SVH
`define GLUE_DEFS_SVH
`define WAIT_CFG_OFS 8'h00
`define REGION_OFS 8'h04
`define TRAP_OFS 8'h08
`define STATUS_OFS 8'h0c
`define DMA_CTRL_OFS 8'h10
`define WC_MEM0_LSB 0
`define WC_MEM1_LSB 2
`define WC_MEM2_LSB 4
`define WC_IO_LSB 6
`define WC_REF_LSB 8
`define WC_DMA_LSB 10
`define WC_RESET 12'h5ea
`define RG_R1_LSB 0
`define RG_R2_LSB 4
`define RG_RESET 8'hea
`define TR_FLAG_BIT 0
`define TR_DIR_BIT 1
`define TR_ADDR_LSB 16
`define ST_IRQ_LSB 0
`define ST_REF_BIT 8
`define ST_JMP_BIT 9
`define ST_GNT_LSB 10
`define DC_ROT_BIT 0
`define LEG_DMA_HI 10'h01f
`define LEG_PAGE_LO 10'h080
`define LEG_PAGE_HI 10'h08f
`define JMP_FIXED 1'b1
`define DMA_FIXED_WAIT 3'h5
`define TB_DIV_DEF 6
`endif

/* shared/glue_pkg.sv */
// Types shared by the PC compatibility glue.
package glue_pkg;
  typedef enum logic [1:0] {CYC_MEM = 2'h0, CYC_IO = 2'h1, CYC_REF = 2'h2, CYC_DMA = 2'h3} cyc_kind_t;
  typedef struct packed {
    logic start;
    cyc_kind_t kind;
    logic wr;
    logic [19:0] addr;
  } cpu_cyc_t;
  typedef enum logic [1:0] {WS_IDLE = 2'h1, WS_BUSY = 2'h2} ws_state_t;
endpackage : glue_pkg

/* tb/core_model.sv */
// Behavioural host core model: timer outputs, refresh bursts and DMA acknowledges.
`timescale 1ns/1ps
module core_model (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Glue side.
  input wire logic timer_tick_i,
  input wire logic [3:0] dma_req_i,
  output logic [2:0] timer_out_o,
  output logic [2:0] dma_ack_o,
  output logic refresh_req_o
);
  logic [5:0] tick_cnt_r;
  logic [5:0] ref_cnt_r;
  logic [2:0] ack_r;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_r <= 6'h00;
      ref_cnt_r <= 6'h00;
      ack_r <= 3'h0;
    end else begin
      if (timer_tick_i) begin
        tick_cnt_r <= tick_cnt_r + 6'h01;
      end
      ref_cnt_r <= ref_cnt_r + 6'h01;
      ack_r <= dma_req_i[2:0];
    end
  end
  assign timer_out_o = {tick_cnt_r[2], tick_cnt_r[1], tick_cnt_r[3]};
  // Refresh arrives as a single pulse and a four-cycle back-to-back burst with uneven gaps, the whole pattern repeating every 64 cycles.
  assign refresh_req_o = (ref_cnt_r[5:2] == 4'h9) || (ref_cnt_r == 6'h05);
  assign dma_ack_o = ack_r & dma_req_i[2:0];
endmodule : core_model

/* tb/pc_compat_peripheral_glue_test.sv */
// Self-checking bench for the PC compatibility glue.
`timescale 1ns/1ps
`include "glue_defs.svh"
module pc_compat_peripheral_glue_test;
  import glue_pkg::*;
  localparam int TB_DIV = 6;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, kbd_irq_i = 1'b0, jumper = 1'b0, mon_en = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, rnd = 32'h6be70ab9, texp = 32'h0;
  logic wb_ack_o, cpu_ready_o, nmi_o, timer_tick_o, serial_baud_o, speaker_tone_o, refresh_req;
  cpu_cyc_t cpu_cyc_i = '0;
  logic [2:0] timer_out, dma_ack, ch_prev;
  logic [7:2] bus_irq_i = 6'h00;
  logic [7:0] irq_o, rg;
  logic [3:1] bus_drq_i = 3'h0;
  logic [3:0] bus_dack_o, dma_req_o, dack_exp;
  logic [11:0] cfg;
  logic [9:0] taddr [8] = '{10'h000, 10'h01f, 10'h080, 10'h08f, 10'h00a, 10'h020, 10'h07f, 10'h090};
  int num_errors = 0, checks_done = 0, gap = -1000;

  pc_compat_peripheral_glue #(.TB_DIV(TB_DIV)) u_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_cyc_i(cpu_cyc_i),
    .cpu_ready_o(cpu_ready_o), .nmi_o(nmi_o), .timer_tick_o(timer_tick_o), .timer_ch0_out_i(timer_out[0]),
    .timer_ch1_out_i(timer_out[1]), .timer_ch2_out_i(timer_out[2]), .serial_baud_o(serial_baud_o),
    .speaker_tone_o(speaker_tone_o), .bus_irq_i(bus_irq_i), .kbd_irq_i(kbd_irq_i), .irq_o(irq_o),
    .bus_drq_i(bus_drq_i), .bus_dack_o(bus_dack_o), .dma_req_o(dma_req_o), .dma_ack_i(dma_ack),
    .refresh_req_i(refresh_req), .dma_wait_jumper_i(jumper));
  core_model u_core (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .timer_tick_i(timer_tick_o),
    .dma_req_i(dma_req_o), .timer_out_o(timer_out), .dma_ack_o(dma_ack), .refresh_req_o(refresh_req));

  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [3:0] exp_w(input logic [1:0] k, input logic [19:0] a, input logic j);
    case (k)
      2'h0: return 4'(a[19:16] >= rg[7:4] ? cfg[5:4] : a[19:16] >= rg[3:0] ? cfg[3:2] : cfg[1:0]);
      2'h1: return 4'(cfg[7:6]);
      2'h2: return 4'(cfg[9:8]);
      default: return j ? 4'h5 : (cfg[11:10] == 2'h0 ? 4'h1 : 4'(cfg[11:10]));
    endcase
  endfunction : exp_w

  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk("wb ack", 32'h1, 32'h0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(what, exp, rd);
  endtask : rd_chk

  task cyc(input logic [1:0] k, input logic [19:0] a, input logic w, input logic [3:0] exp);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cpu_cyc_i <= cpu_cyc_t'({1'b1, k, w, a});
    #1;
    while (cpu_ready_o !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      cpu_cyc_i.start <= 1'b0;
      #1;
      n++;
    end
    @(posedge ref_clk_i);
    cpu_cyc_i.start <= 1'b0;
    chk("wait states", 32'(exp), n);
  endtask : cyc

  task close_out();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  always @(posedge ref_clk_i) begin
    dack_exp <= {dma_ack, refresh_req};
    ch_prev <= timer_out;
  end

  always @(negedge ref_clk_i) begin
    if (mon_en) begin
      chk("dack", 32'(dack_exp), 32'(bus_dack_o));
      chk("baud", 32'(ch_prev[1]), 32'(serial_baud_o));
      chk("tone", 32'(ch_prev[2]), 32'(speaker_tone_o));
      chk("irq0", 32'(ch_prev[0]), 32'(irq_o[0]));
      chk("channel three", 32'h0, 32'(dma_req_o[3]));
      if (gap >= 0 && (timer_tick_o || gap >= TB_DIV)) chk("tick gap", TB_DIV - 1, gap);
      gap = timer_tick_o ? 0 : gap + 1;
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    mon_en <= 1'b1;
    rd_chk("wait cfg reset", `WAIT_CFG_OFS, 32'h5ea);
    rd_chk("region reset", `REGION_OFS, 32'hea);
    rd_chk("unmapped", 8'h20, 32'h0);
    repeat (8) begin
      rnd = lfsr(rnd);
      @(posedge ref_clk_i);
      bus_irq_i <= rnd[7:2];
      kbd_irq_i <= rnd[1];
      repeat (4) @(posedge ref_clk_i);
      chk("irq lines", 32'({rnd[7:2], rnd[1]}), 32'(irq_o[7:1]));
    end
    for (int ch = 1; ch < 5; ch++) begin
      @(posedge ref_clk_i);
      bus_drq_i <= (ch == 4) ? 3'h7 : 3'(1 << (ch - 1));
      repeat (5) @(posedge ref_clk_i);
      chk("native request", (ch == 4) ? 32'h1 : 32'(1 << (ch - 2 + 1)), 32'(dma_req_o));
      bus_drq_i <= 3'h0;
      repeat (4) @(posedge ref_clk_i);
    end
    // Rotating priority: the channel served last drops to the bottom, starting after native 0.
    wb(1'b1, `DMA_CTRL_OFS, 32'h1);
    rd_chk("rotate mode", `DMA_CTRL_OFS, 32'h1);
    for (int r = 0; r < 3; r++) begin
      @(posedge ref_clk_i);
      bus_drq_i <= 3'h7;
      repeat (5) @(posedge ref_clk_i);
      chk("rotating grant", 32'(1 << ((r + 1) % 3)), 32'(dma_req_o));
      bus_drq_i <= 3'h0;
      repeat (4) @(posedge ref_clk_i);
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      cyc(2'h1, {rnd[19:10], taddr[i]}, rnd[0], 4'h3);
      chk("nmi", 32'(i < 5), 32'(nmi_o));
      if (i < 5) texp = {6'h0, taddr[i], 14'h0, rnd[0], 1'b0};
      rd_chk("trap reg", `TRAP_OFS, texp | 32'(i < 5));
      wb(1'b1, `TRAP_OFS, 32'h1);
      @(posedge ref_clk_i);
      chk("nmi cleared", 32'h0, 32'(nmi_o));
    end
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      cfg = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : rnd[11:0];
      // Firmware timing: two memory, three I/O, one refresh and one DMA wait.
      if (i == 2) cfg = 12'h5ea;
      rg = rnd[19:12];
      jumper <= (i < 2) ? 1'b0 : rnd[20];
      wb(1'b1, `WAIT_CFG_OFS, 32'(cfg));
      wb(1'b1, `REGION_OFS, 32'(rg));
      repeat (4) @(posedge ref_clk_i);
      for (int k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        cyc(2'(k), rnd[19:0], rnd[20], exp_w(2'(k), rnd[19:0], jumper));
      end
    end
    close_out();
  end
endmodule : pc_compat_peripheral_glue_test
